// ### can_fbm_cfg.svh
/*
  Constants for the CAN frame buffer manager: register offsets, field positions,
  data type codes and reset values.
  Assumes inclusion by bare name from every file that needs the figures.
*/
`ifndef CAN_FBM_CFG_SVH
`define CAN_FBM_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses on the APB)
`define REG_CTRL        12'h000
`define REG_FILT_CODE   12'h004
`define REG_FILT_MASK   12'h008
`define REG_OP_SLOT     12'h00c
`define REG_OP_DATA     12'h010
`define REG_OP_RESULT   12'h014
`define REG_STATUS      12'h018
`define REG_COUNTERS    12'h01c
`define REGION_SET      4'h1
`define REGION_SLOT     4'h2
`define SET_REG_ID      2'h0
`define SET_REG_CFG     2'h1
`define SET_REG_RB_LO   2'h2
`define SET_REG_RB_HI   2'h3

// ==========================================================================
// Field positions
`define CTRL_MRD        0
`define CFG_EN          0
`define CFG_TX          1
`define CFG_REMOTE      2
`define SLOT_TYPE_LSB   0
`define SLOT_SET_LSB    8
`define SLOT_START_LSB  16
`define SLOT_LEN_LSB    24
`define STATUS_CNT_LSB  16

// ==========================================================================
// Reset values and fixed figures
`define CTRL_RST        1'b0
`define CFG_RST         3'h0
`define OVER_RANGE      32'hfffe7961
`define FULL_MASK       32'hffffffff
`define FULL_LEN        6'h20

// ==========================================================================
// Data type codes
`define DT_RETR_FIRST   5'h01
`define DT_RETR_LAST    5'h06
`define DT_BUILD_FIRST  5'h07
`define DT_BUILD_LAST   5'h0c
`define DT_OR_FIRST     5'h0d
`define DT_OR_LAST      5'h12
`define DT_TXV_FIRST    5'h13
`define DT_TXV_LAST     5'h18
`define DT_SEND         5'h19
`define DT_ARM          5'h1a
`define DT_CTR          5'h1b
`define DT_CTR_CLR      5'h1c

`endif

// ### can_fbm_pkg.sv
/*
  Types shared by the CAN frame buffer manager files.
  Assumes nothing of its surroundings.
*/
package can_fbm_pkg;

  // ========================================================================
  // Transmit scanner states, one-hot
  typedef enum logic [1:0] {
    SCAN_LOOK = 2'b01,
    SCAN_SEND = 2'b10
  } scan_state_t;

  // ========================================================================
  // Value kinds within each group of six data type codes
  typedef enum logic [1:0] {
    KIND_UNSIGNED = 2'b00,
    KIND_SIGNED   = 2'b01,
    KIND_FLOAT    = 2'b10
  } val_kind_t;

endpackage

// ### rx_frame_fifo.sv
/*
  Small receive FIFO of whole frames held in flip-flops.
  Assumes one clock and an asynchronous active-low reset; push is refused
  while full, pop only while not empty.
*/
`timescale 1ns/100ps
`default_nettype none

module rx_frame_fifo #(
  parameter int WIDTH = 94,
  parameter int DEPTH = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic            [3:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Handshake
  assign in_ready  = (level != 4'(DEPTH));
  assign out_valid = (level != 4'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage written at the write pointer
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the last entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 4'h0;
    end else if (push && !pop) begin
      level <= level + 4'h1;
    end else if (pop && !push) begin
      level <= level - 4'h1;
    end
  end

endmodule

`default_nettype wire

// ### can_frame_buffer_manager.sv
/*
  CAN frame buffer manager: coarse receive filter, three-frame receive FIFO,
  exact-ID buffer sets, per-slot new-data flags, frame building and a
  transmit scanner, all reached over an APB slave.
  Assumes pclk at 200 MHz, presetn asynchronous active low, a CAN controller
  that presents frames as one-cycle pulses and reports tx_busy.
*/
// Summary of operation
// - Coarse ID pattern filter drops frames first
// - Passing frames queue in three-frame FIFO
// - Interrupt request held while FIFO non-empty
// - Exact ID match lands frame in set
// - Set holds config, ID, working, read buffers
// - Slots with same ID share one set
// - Slot records type, set, own flag
// - Landing frame sets all flags of set
// - Stale read gives old value or over-range
// - Read clears only requesting slot's flag
// - Slot number first, then data, per setup
// - Values shifted into 64-bit read buffer
// - Complete frame queued or armed as response
// - Queuing sets transmit-pending flag of set
// - Scanner waits idle transmitter, sends, clears pending
// - Armed frame copied into working buffer
// - Remote request sets pending of matching set
// - Codes 1-6 retrieve values, odd MSB-first
// - Codes 7-12 write value into frame
// - Codes 13-18 OR value into frame
// - Codes 19-24 place value and queue
// - Codes 25-28 send, arm, counters, clear
`timescale 1ns/100ps
`default_nettype none
`include "can_fbm_cfg.svh"

module can_frame_buffer_manager
  import can_fbm_pkg::*;
#(
  parameter int NUM_SETS   = 4,
  parameter int NUM_SLOTS  = 8,
  parameter int FIFO_DEPTH = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic        rx_remote,
  input  wire logic [28:0] rx_id,
  input  wire logic [63:0] rx_data,
  output logic             rx_irq,
  output logic             tx_valid,
  output logic      [28:0] tx_id,
  output logic      [63:0] tx_data,
  input  wire logic        tx_busy
);
  localparam int SW = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
  localparam int LW = (NUM_SLOTS > 1) ? $clog2(NUM_SLOTS) : 1;
  localparam int QW = 94;
  localparam logic [SW-1:0] SET_LAST = SW'(NUM_SETS - 1);

  // ==========================================================================
  // Helpers
  function automatic logic [63:0] swap64(input logic [63:0] d);
    logic [63:0] r;
    r = '0;
    for (int b = 0; b < 8; b++) begin
      r[b*8 +: 8] = d[(7-b)*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [4:0] c, input logic [4:0] lo,
                                    input logic [4:0] hi);
    return (c >= lo) && (c <= hi);
  endfunction

  // ==========================================================================
  // Declarations
  logic              ctrl_mrd;
  logic [28:0]       filt_code;
  logic [28:0]       filt_mask;
  logic [LW-1:0]     cur_slot;
  logic [31:0]       op_result;
  logic [15:0]       rx_count;
  logic [15:0]       ovr_count;
  logic [28:0]       set_id   [NUM_SETS];
  logic [2:0]        set_cfg  [NUM_SETS];
  logic [63:0]       work_buf [NUM_SETS];
  logic [63:0]       read_buf [NUM_SETS];
  logic              pending  [NUM_SETS];
  logic [4:0]        slot_type  [NUM_SLOTS];
  logic [SW-1:0]     slot_set   [NUM_SLOTS];
  logic [5:0]        slot_start [NUM_SLOTS];
  logic [5:0]        slot_len   [NUM_SLOTS];
  logic              new_flag   [NUM_SLOTS];
  logic              wr_en;
  logic              sel_set;
  logic              sel_slot;
  logic [SW-1:0]     set_idx;
  logic [LW-1:0]     slot_idx;
  logic              op_slot_wr;
  logic              op_data_wr;
  logic [LW-1:0]     act_slot;
  logic [4:0]        act_type;
  logic [SW-1:0]     act_set;
  logic [5:0]        act_start;
  logic [5:0]        act_len;
  logic [4:0]        rel;
  val_kind_t         kind;
  logic              lsb_first;
  logic [31:0]       fmask;
  logic [31:0]       fld;
  logic [63:0]       ext;
  logic [63:0]       nb;
  logic [63:0]       next_rb;
  logic              do_retr;
  logic              do_build;
  logic              do_queue;
  logic              do_arm;
  logic              do_ctr;
  logic              coarse_ok;
  logic              fifo_ready;
  logic              q_valid;
  logic [QW-1:0]     q_data;
  logic [3:0]        fifo_level;
  logic              hit_any;
  logic [SW-1:0]     hit_idx;
  logic              land;
  logic              rtr_acc;
  scan_state_t       scan_state;
  logic [SW-1:0]     scan_ptr;
  logic              scan_clear;
  logic [31:0]       rd_mux;
  logic              rd_ok;
  logic [31:0]       pend_vec;

  // ==========================================================================
  // APB decode; every transfer is answered in its first access cycle
  assign pready   = psel & penable;
  assign wr_en    = psel & penable & pwrite;
  assign sel_set  = (paddr[11:8] == `REGION_SET) && (int'(paddr[7:4]) < NUM_SETS);
  assign sel_slot = (paddr[11:8] == `REGION_SLOT) && (int'(paddr[7:2]) < NUM_SLOTS);
  assign set_idx  = paddr[4 +: SW];
  assign slot_idx = paddr[2 +: LW];
  assign op_slot_wr = wr_en && (paddr == `REG_OP_SLOT);
  assign op_data_wr = wr_en && (paddr == `REG_OP_DATA);

  // Control and filter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mrd  <= `CTRL_RST;
      filt_code <= '0;
      filt_mask <= '0;
    end else if (wr_en) begin
      if (paddr == `REG_CTRL) ctrl_mrd <= pwdata[`CTRL_MRD];
      if (paddr == `REG_FILT_CODE) filt_code <= pwdata[28:0];
      if (paddr == `REG_FILT_MASK) filt_mask <= pwdata[28:0];
    end
  end

  // Slot table, one entry per host instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        slot_type[s]  <= '0;
        slot_set[s]   <= '0;
        slot_start[s] <= '0;
        slot_len[s]   <= '0;
      end
    end else if (wr_en && sel_slot) begin
      slot_type[slot_idx]  <= pwdata[`SLOT_TYPE_LSB +: 5];
      slot_set[slot_idx]   <= pwdata[`SLOT_SET_LSB +: SW];
      slot_start[slot_idx] <= pwdata[`SLOT_START_LSB +: 6];
      slot_len[slot_idx]   <= pwdata[`SLOT_LEN_LSB +: 6];
    end
  end

  // Slot number is latched first; data writes then act on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_slot <= '0;
    end else if (op_slot_wr) begin
      cur_slot <= pwdata[LW-1:0];
    end
  end

  // ==========================================================================
  // Host operation decode from the slot's compiled setup
  always_comb begin
    act_slot  = op_slot_wr ? pwdata[LW-1:0] : cur_slot;
    act_type  = slot_type[act_slot];
    act_set   = slot_set[act_slot];
    act_start = slot_start[act_slot];
    act_len   = slot_len[act_slot];
    do_retr   = op_slot_wr && in_range(act_type, `DT_RETR_FIRST, `DT_RETR_LAST);
    do_build  = op_data_wr && in_range(act_type, `DT_BUILD_FIRST, `DT_TXV_LAST);
    do_queue  = (op_data_wr && in_range(act_type, `DT_TXV_FIRST, `DT_TXV_LAST))
             || (op_slot_wr && act_type == `DT_SEND);
    do_arm    = op_slot_wr && act_type == `DT_ARM;
    do_ctr    = op_slot_wr && in_range(act_type, `DT_CTR, `DT_CTR_CLR);
    if (in_range(act_type, `DT_TXV_FIRST, `DT_TXV_LAST)) rel = act_type - `DT_TXV_FIRST;
    else if (in_range(act_type, `DT_OR_FIRST, `DT_OR_LAST)) rel = act_type - `DT_OR_FIRST;
    else if (in_range(act_type, `DT_BUILD_FIRST, `DT_BUILD_LAST)) rel = act_type - `DT_BUILD_FIRST;
    else rel = act_type - `DT_RETR_FIRST;
    kind      = val_kind_t'(rel[2:1]);
    lsb_first = ~act_type[0];
    if (kind == KIND_FLOAT || act_len == 6'h0 || act_len >= `FULL_LEN) fmask = `FULL_MASK;
    else fmask = (32'h1 << act_len) - 32'h1;
  end

  // Retrieve: extract, sign-extend or pass float bits
  always_comb begin
    ext = (lsb_first ? swap64(work_buf[act_set]) : work_buf[act_set]) >> act_start;
    fld = ext[31:0] & fmask;
    if (kind == KIND_SIGNED && (fld & ~(fmask >> 1)) != 32'h0) begin
      fld = fld | ~fmask;
    end
  end

  // Build: clear-and-insert or OR-merge into the 64-bit read buffer
  always_comb begin
    nb = lsb_first ? swap64(read_buf[act_set]) : read_buf[act_set];
    if (in_range(act_type, `DT_OR_FIRST, `DT_OR_LAST)) begin
      nb = nb | ({32'h0, pwdata & fmask} << act_start);
    end else begin
      nb = (nb & ~({32'h0, fmask} << act_start))
         | ({32'h0, pwdata & fmask} << act_start);
    end
    next_rb = lsb_first ? swap64(nb) : nb;
  end

  // Operation result for retrieve and counter codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_result <= '0;
    end else if (do_retr) begin
      op_result <= (!new_flag[act_slot] && ctrl_mrd) ? `OVER_RANGE : fld;
    end else if (do_ctr) begin
      op_result <= {ovr_count, rx_count};
    end
  end

  // ==========================================================================
  // Receive path
  assign coarse_ok = ((rx_id ^ filt_code) & filt_mask) == 29'h0;
  assign rx_irq    = q_valid;

  rx_frame_fifo #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (rx_valid & coarse_ok),
    .in_ready  (fifo_ready),
    .in_data   ({rx_remote, rx_id, rx_data}),
    .out_valid (q_valid),
    .out_ready (1'b1),
    .out_data  (q_data),
    .level     (fifo_level)
  );

  // Exact match of the drained frame, lowest set first
  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = NUM_SETS - 1; i >= 0; i--) begin
      if (set_cfg[i][`CFG_EN] && set_id[i] == q_data[92:64]) begin
        hit_any = 1'b1;
        hit_idx = SW'(i);
      end
    end
  end

  assign land    = q_valid && !q_data[93] && hit_any && !set_cfg[hit_idx][`CFG_TX];
  assign rtr_acc = q_valid && q_data[93] && hit_any && set_cfg[hit_idx][`CFG_REMOTE];

  // Counters: accepted frames and overruns; events win over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_count  <= '0;
      ovr_count <= '0;
    end else begin
      if (do_ctr && act_type == `DT_CTR_CLR) begin
        rx_count  <= land ? 16'h1 : 16'h0;
        ovr_count <= (rx_valid && coarse_ok && !fifo_ready) ? 16'h1 : 16'h0;
      end else begin
        if (land) rx_count <= rx_count + 16'h1;
        if (rx_valid && coarse_ok && !fifo_ready) ovr_count <= ovr_count + 16'h1;
      end
    end
  end

  // ==========================================================================
  // Buffer sets
  generate
    for (genvar i = 0; i < NUM_SETS; i++) begin : g_set
      // Identifier and configuration; arming marks the set remote
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          set_id[i]  <= '0;
          set_cfg[i] <= `CFG_RST;
        end else if (wr_en && sel_set && set_idx == SW'(i)) begin
          if (paddr[3:2] == `SET_REG_ID) set_id[i] <= pwdata[28:0];
          if (paddr[3:2] == `SET_REG_CFG) set_cfg[i] <= pwdata[2:0];
        end else if (do_arm && act_set == SW'(i)) begin
          set_cfg[i][`CFG_REMOTE] <= 1'b1;
        end
      end

      // Read buffer holds the frame under construction
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          read_buf[i] <= '0;
        end else if (do_build && act_set == SW'(i)) begin
          read_buf[i] <= next_rb;
        end
      end

      // Working buffer takes received frames or an armed response
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          work_buf[i] <= '0;
        end else if (land && hit_idx == SW'(i)) begin
          work_buf[i] <= q_data[63:0];
        end else if (do_arm && act_set == SW'(i)) begin
          work_buf[i] <= read_buf[i];
        end
      end

      // Transmit pending: set wins over the scanner's clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pending[i] <= 1'b0;
        end else if ((do_queue && act_set == SW'(i)) || (rtr_acc && hit_idx == SW'(i))) begin
          pending[i] <= 1'b1;
        end else if (scan_clear && scan_ptr == SW'(i)) begin
          pending[i] <= 1'b0;
        end
      end
      assign pend_vec[i] = pending[i];
    end
    for (genvar i = NUM_SETS; i < 32; i++) begin : g_pend_pad
      assign pend_vec[i] = 1'b0;
    end

    // New-data flag per slot: landing sets all of a set, read clears own
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          new_flag[s] <= 1'b0;
        end else if (land && hit_idx == slot_set[s]) begin
          new_flag[s] <= 1'b1;
        end else if (do_retr && act_slot == LW'(s)) begin
          new_flag[s] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Transmit scanner, ascending over the sets
  assign scan_clear = (scan_state == SCAN_SEND) && !tx_busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_state <= SCAN_LOOK;
      scan_ptr   <= '0;
    end else begin
      case (scan_state)
        SCAN_LOOK: begin
          if (pending[scan_ptr] && set_cfg[scan_ptr][`CFG_TX]) begin
            scan_state <= SCAN_SEND;
          end else begin
            scan_ptr <= (scan_ptr == SET_LAST) ? '0 : scan_ptr + 1'b1;
          end
        end
        SCAN_SEND: begin
          if (!tx_busy) begin
            scan_state <= SCAN_LOOK;
            scan_ptr   <= (scan_ptr == SET_LAST) ? '0 : scan_ptr + 1'b1;
          end
        end
        default: begin
          scan_state <= SCAN_LOOK;
        end
      endcase
    end
  end

  // Hand-over to the controller once it is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_id    <= '0;
      tx_data  <= '0;
    end else begin
      tx_valid <= scan_clear;
      if (scan_clear) begin
        tx_id   <= set_id[scan_ptr];
        tx_data <= set_cfg[scan_ptr][`CFG_REMOTE] ? work_buf[scan_ptr] : read_buf[scan_ptr];
      end
    end
  end

  // ==========================================================================
  // Read mux, captured in the setup cycle
  always_comb begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    if (sel_set) begin
      case (paddr[3:2])
        `SET_REG_ID:    rd_mux = {3'h0, set_id[set_idx]};
        `SET_REG_CFG:   rd_mux = {29'h0, set_cfg[set_idx]};
        `SET_REG_RB_LO: rd_mux = read_buf[set_idx][31:0];
        default:        rd_mux = read_buf[set_idx][63:32];
      endcase
    end else if (sel_slot) begin
      rd_mux = {2'h0, slot_len[slot_idx], 2'h0, slot_start[slot_idx], 3'h0,
                5'(slot_set[slot_idx]), 3'h0, slot_type[slot_idx]};
    end else begin
      case (paddr)
        `REG_CTRL:      rd_mux = {31'h0, ctrl_mrd};
        `REG_FILT_CODE: rd_mux = {3'h0, filt_code};
        `REG_FILT_MASK: rd_mux = {3'h0, filt_mask};
        `REG_OP_SLOT:   rd_mux = 32'(cur_slot);
        `REG_OP_RESULT: rd_mux = op_result;
        `REG_STATUS:    rd_mux = (pend_vec & 32'hffff) | (32'(fifo_level) << `STATUS_CNT_LSB);
        `REG_COUNTERS:  rd_mux = {ovr_count, rx_count};
        `REG_OP_DATA:   rd_mux = 32'h0;
        default:        rd_ok  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= rd_mux;
      pslverr <= !rd_ok;
    end
  end

endmodule

`default_nettype wire

// ### can_fbm_sva.sv
/* Port checker for the CAN frame buffer manager.
   Assumes binding to can_frame_buffer_manager, one clock pclk. */
`timescale 1ns/100ps
`default_nettype none
module can_fbm_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_valid,
  input wire logic        rx_irq,
  input wire logic        tx_valid,
  input wire logic [28:0] tx_id,
  input wire logic [63:0] tx_data,
  input wire logic        tx_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus answers
  chk_ready_zero_wait: assert property (
    pready == (psel && penable)) else $error("pready not in first access cycle");
  chk_unmapped_err: assert property (
    psel && penable && paddr == 12'h020 |-> pslverr) else $error("no error on hole");
  chk_status_ok: assert property (
    psel && penable && paddr == 12'h018 |-> !pslverr) else $error("error on status");
  // ==========
  // Receive request line
  chk_irq_cause: assert property (
    $rose(rx_irq) |-> $past(rx_valid)) else $error("irq without frame");
  chk_irq_drain: assert property (
    (!rx_valid) [*4] |-> !rx_irq) else $error("irq held with fifo drained");
  // ==========
  // Transmit hand-over
  chk_tx_pulse: assert property (
    tx_valid |=> !tx_valid) else $error("tx_valid wider than one cycle");
  chk_tx_idle_first: assert property (
    tx_valid |-> !$past(tx_busy)) else $error("frame handed to busy transmitter");
  chk_tx_frame_holds: assert property (
    !tx_valid |-> $stable(tx_id) && $stable(tx_data)) else $error("tx frame moved");
  cover property (tx_valid);
  cover property ($rose(rx_irq));
  cover property (pslverr && pready);
endmodule
bind can_frame_buffer_manager can_fbm_sva i_can_fbm_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_irq(rx_irq), .tx_valid(tx_valid), .tx_id(tx_id),
  .tx_data(tx_data), .tx_busy(tx_busy));
`default_nettype wire

// ### can_node_model.sv
/* Behavioural CAN controller beside the block: offers frames, then
   stays busy for twelve cycles after each frame it is handed.
   Assumes pclk from the testbench. */
`timescale 1ns/100ps
`default_nettype none
module can_node_model (
  input  wire logic        pclk,
  input  wire logic        tx_valid,
  output logic             rx_valid,
  output logic             rx_remote,
  output logic      [28:0] rx_id,
  output logic      [63:0] rx_data,
  output logic             tx_busy
);
  logic [3:0] busy_cnt = 4'h0;
  initial rx_valid = 1'b0;
  initial rx_remote = 1'b0;
  // Transmitter stays busy after each hand-over
  always @(posedge pclk) begin
    if (tx_valid) busy_cnt <= 4'hc;
    else if (busy_cnt != 4'h0) busy_cnt <= busy_cnt - 4'h1;
  end
  assign tx_busy = (busy_cnt != 4'h0);
  // One-cycle frame offer; lines inverted once released
  task send_frame(input logic r, input logic [28:0] id, input logic [63:0] d);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_remote <= r;
    rx_id <= id;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_remote <= ~r;
    rx_id <= ~id;
    rx_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
/* Self-checking bench for the CAN frame buffer manager.
   Assumes can_node_model as the controller and an APB master here. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rx_valid, rx_remote, rx_irq, tx_valid, tx_busy;
  logic [28:0] rx_id, tx_id;
  logic [63:0] rx_data, tx_data;
  int err_count = 0, compares = 0;
  // Clock
  always #2.5 pclk = ~pclk;
  can_frame_buffer_manager i_can_frame_buffer_manager (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_remote(rx_remote), .rx_id(rx_id), .rx_data(rx_data), .rx_irq(rx_irq),
    .tx_valid(tx_valid), .tx_id(tx_id), .tx_data(tx_data), .tx_busy(tx_busy));
  can_node_model i_can_node_model (.pclk(pclk), .tx_valid(tx_valid), .rx_valid(rx_valid),
    .rx_remote(rx_remote), .rx_id(rx_id), .rx_data(rx_data), .tx_busy(tx_busy));
  // ==========
  // Helpers
  task cmp(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Slot number first, then the result of the retrieve
  task chk_slot(input logic [31:0] s, input logic [63:0] e, input string n);
    apb(1'b1, 12'h00c, s);
    apb(1'b0, 12'h014, 32'h0);
    cmp(n, e, rd);
  endtask
  task wait_tx;
    do @(negedge pclk); while (tx_valid !== 1'b1);
    @(posedge pclk);
  endtask
  // ==========
  // Scenarios
  task t_rx;
    apb(1'b1, 12'h100, 32'h123);
    apb(1'b1, 12'h104, 32'h1);
    apb(1'b1, 12'h200, 32'h08000001);
    apb(1'b1, 12'h204, 32'h08080001);
    i_can_node_model.send_frame(1'b0, 29'h123, 64'h1122334455667788);
    @(negedge pclk) cmp("rx_irq", 64'h1, rx_irq);
    i_can_node_model.send_frame(1'b0, 29'h124, 64'hffffffffffffffff);
    repeat (4) @(posedge pclk);
    chk_slot(32'h0, 64'h88, "slot0 fresh");
    apb(1'b1, 12'h000, 32'h1);
    chk_slot(32'h0, 64'hfffe7961, "slot0 stale");
    chk_slot(32'h1, 64'h77, "slot1 shared");
    apb(1'b1, 12'h004, 32'h124);
    apb(1'b1, 12'h008, 32'h1fffffff);
    i_can_node_model.send_frame(1'b0, 29'h123, 64'h0);
    repeat (4) @(posedge pclk);
    chk_slot(32'h1, 64'hfffe7961, "slot1 filtered");
    apb(1'b0, 12'h01c, 32'h0);
    cmp("counters", 64'h1, rd);
    apb(1'b0, 12'h020, 32'h0);
    cmp("pslverr", 64'h1, pslverr);
  endtask
  task t_tx;
    apb(1'b1, 12'h110, 32'h2aa);
    apb(1'b1, 12'h114, 32'h3);
    apb(1'b1, 12'h208, 32'h10000107);
    apb(1'b1, 12'h20c, 32'h00000119);
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h010, 32'hbeef);
    apb(1'b1, 12'h00c, 32'h3);
    wait_tx;
    cmp("tx_id", 64'h2aa, tx_id);
    cmp("tx_data", 64'hbeef, tx_data);
    apb(1'b1, 12'h00c, 32'h3);
    wait_tx;
    cmp("tx_data again", 64'hbeef, tx_data);
    apb(1'b0, 12'h018, 32'h0);
    cmp("status", 64'h0, rd);
  endtask
  // Arm set 1 as a response, rebuild its read buffer, then request it remotely
  task t_rtr;
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h210, 32'h0000011a);
    apb(1'b1, 12'h00c, 32'h4);
    apb(1'b0, 12'h114, 32'h0);
    cmp("armed cfg", 64'h7, rd);
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h010, 32'h5678);
    i_can_node_model.send_frame(1'b1, 29'h2aa, 64'h0);
    wait_tx;
    cmp("rtr tx_id", 64'h2aa, tx_id);
    cmp("rtr tx_data", 64'hbeef, tx_data);
  endtask
  task finish_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_rx;
    t_tx;
    t_rtr;
    finish_test;
  end
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
endmodule
`default_nettype wire
